/* File: hdl/tsi_entry_check.sv */
// module: range check of one written table field
`timescale 1ns/1ps
`default_nettype none
module tsi_entry_check
  import tsi_pkg::*;
(
  input wire logic [3:0] field, // field being written
  input wire logic [23:0] wdata, // raw value
  input wire logic [12:0] cur_width, // entry width now
  input wire logic [11:0] cur_height, // entry height now
  input wire logic [1:0] cur_binh, // entry h binning
  input wire logic [1:0] cur_binv, // entry v binning
  output logic accept // value legal for the field
);
  logic [12:0] xmax; // x extent for the binning
  logic [11:0] ymax; // y extent for the binning
  logic [12:0] xlim; // x offset limit
  logic [11:0] ylim; // y offset limit
  // legality per field
  always_comb begin
    xmax = (cur_binh == BIN_ON) ? WIDTH_HBIN_MAX : WIDTH_MAX;
    ymax = (cur_binv == BIN_ON) ? HEIGHT_VBIN_MAX : HEIGHT_MAX;
    // limits only mean something while the size fits the extent
    xlim = xmax - cur_width;
    ylim = ymax - cur_height;
    unique case (field)
      4'(FLD_WIDTH): accept = wdata[12:0] >= WIDTH_MIN && wdata[12:0] <= WIDTH_MAX
        && wdata[23:13] == 11'h000;
      4'(FLD_HEIGHT): accept = wdata[11:0] >= HEIGHT_MIN && wdata[11:0] <= HEIGHT_MAX
        && wdata[23:12] == 12'h000;
      4'(FLD_OFFX): accept = wdata[23:13] == 11'h000 && cur_width <= xmax
        && wdata[12:0] <= xlim;
      4'(FLD_OFFY): accept = wdata[23:12] == 12'h000 && cur_height <= ymax
        && wdata[11:0] <= ylim;
      4'(FLD_BINH), 4'(FLD_BINV): accept = wdata == {22'h000000, BIN_OFF}
        || wdata == {22'h000000, BIN_ON};
      4'(FLD_COUNT): accept = wdata[23:16] == 8'h00 && wdata[15:0] != 16'h0000;
      4'(FLD_NEXT): accept = wdata < 24'(NUM_ENTRIES);
      default: accept = field < 4'(NUM_FIELDS);
    endcase
  end
endmodule : tsi_entry_check
`default_nettype wire

/* File: hdl/tsi_pkg.sv */
// package: constants, table layout and defaults for the trigger sequence indexer
//------------------------------------------------------------
//------------------------------------------------------------
package tsi_pkg;
  localparam int NUM_ENTRIES = 10;
  localparam logic [7:0] ADDR_MODE = 8'h00;
  localparam logic [7:0] ADDR_SEL = 8'h04;
  localparam logic [7:0] ADDR_CMD = 8'h08;
  localparam logic [7:0] ADDR_STAT = 8'h0C;
  localparam logic [7:0] ADDR_FIELD = 8'h10;
  localparam int FLD_WIDTH = 0;
  localparam int FLD_HEIGHT = 1;
  localparam int FLD_OFFX = 2;
  localparam int FLD_OFFY = 3;
  localparam int FLD_GAIN = 4;
  localparam int FLD_GAINR = 5;
  localparam int FLD_GAINB = 6;
  localparam int FLD_EXPO = 7;
  localparam int FLD_BLACK = 8;
  localparam int FLD_BINH = 9;
  localparam int FLD_BINV = 10;
  localparam int FLD_LUT = 11;
  localparam int FLD_COUNT = 12;
  localparam int FLD_NEXT = 13;
  localparam int NUM_FIELDS = 14;
  localparam logic [1:0] MODE_NORMAL = 2'h0;
  localparam logic [1:0] MODE_SEQ = 2'h1;
  localparam logic [1:0] OVL_OFF = 2'h0;
  localparam logic [1:0] OVL_READOUT = 2'h1;
  localparam int CMD_RESET_BIT = 0;
  localparam int CMD_READ_BIT = 1;
  localparam int MODE_OVL_POS = 4;
  localparam logic [12:0] WIDTH_MIN = 13'h0008;
  localparam logic [12:0] WIDTH_MAX = 13'h1400;
  localparam logic [12:0] WIDTH_HBIN_MAX = 13'h0A00;
  localparam logic [11:0] HEIGHT_MIN = 12'h002;
  localparam logic [11:0] HEIGHT_MAX = 12'hF00;
  localparam logic [11:0] HEIGHT_VBIN_MAX = 12'h780;
  localparam logic [23:0] EXPO_DEF = 24'h02BF20;
  localparam logic [1:0] BIN_OFF = 2'h1;
  localparam logic [1:0] BIN_ON = 2'h2;
  localparam logic [15:0] COUNT_DEF = 16'h0001;
  localparam logic [3:0] NEXT_DEF = 4'h0;
endpackage : tsi_pkg

/* File: hdl/tsi_seq_indexer.sv */
// module: trigger sequence indexer top with table, sequencer and register port
`timescale 1ns/1ps
`default_nettype none
module tsi_seq_indexer
  import tsi_pkg::*;
#(
  parameter int ENTRIES = NUM_ENTRIES // table depth
)(
  input wire logic clk_sys, // system clock
  input wire logic srst, // synchronous reset, high
  input wire logic [7:0] addr, // register byte address
  input wire logic [31:0] wdata, // write data
  input wire logic wr, // write strobe
  input wire logic rd, // read strobe
  output logic [31:0] rdata, // read data, cycle after rd
  input wire logic trig, // trigger pulse from source
  input wire logic capture_done, // sensor finished exposure and readout
  output logic cap_start, // one-cycle capture start pulse
  output logic busy, // capture in progress
  output logic overlap_readout, // readout overlap actually enabled
  output logic [3:0] cap_index, // entry used by this capture
  output logic [12:0] cap_width, // roi width
  output logic [11:0] cap_height, // roi height
  output logic [12:0] cap_offx, // roi x offset
  output logic [11:0] cap_offy, // roi y offset
  output logic [15:0] cap_gain, // overall gain
  output logic [15:0] cap_gain_r, // red gain
  output logic [15:0] cap_gain_b, // blue gain
  output logic [23:0] cap_expo, // exposure time
  output logic [9:0] cap_black, // black level
  output logic [1:0] cap_binh, // horizontal binning
  output logic [1:0] cap_binv, // vertical binning
  output logic cap_lut // lut enable
);
  //------------------------------------------------------------
  // types and state
  //------------------------------------------------------------
  typedef enum logic [0:0] {ST_IDLE, ST_BUSY} tsi_state_e;
  typedef struct packed {
    logic [12:0] width; // roi width
    logic [11:0] height; // roi height
    logic [12:0] offx; // x offset
    logic [11:0] offy; // y offset
    logic [15:0] gain; // overall gain
    logic [15:0] gain_r; // red gain
    logic [15:0] gain_b; // blue gain
    logic [23:0] expo; // exposure time
    logic [9:0] black; // black level
    logic [1:0] binh; // h binning
    logic [1:0] binv; // v binning
    logic lut; // lut enable
    logic [15:0] count; // frame count
    logic [3:0] next; // next entry
  } tsi_entry_s;
  typedef struct packed {
    tsi_state_e st; // sequencer state
    logic [1:0] mode; // video send mode
    logic [1:0] ovl; // trigger overlap request
    logic [3:0] sel; // selected entry for access
    logic [3:0] ptr; // current entry pointer
    logic [15:0] rep; // repetitions done on ptr
    logic [3:0] last; // entry of latest trigger
    logic [31:0] rdata; // read data
    logic start; // capture start pulse
    logic [3:0] cidx; // captured entry
    tsi_entry_s cap; // captured parameters
    tsi_entry_s [ENTRIES-1:0] tab; // index table
  } tsi_state_s;

  tsi_state_s s_r; // registered state
  tsi_state_s s_nxt; // next state
  logic accept; // write value legal
  tsi_entry_s sel_e; // selected entry view

  //------------------------------------------------------------
  // helpers
  //------------------------------------------------------------
  // default entry contents
  function automatic tsi_entry_s tsi_default_entry();
    tsi_entry_s e;
    e = '0;
    e.width = WIDTH_MAX;
    e.height = HEIGHT_MAX;
    e.expo = EXPO_DEF;
    e.black = 10'h000;
    e.lut = 1'b0;
    e.binh = BIN_OFF;
    e.binv = BIN_OFF;
    e.count = COUNT_DEF;
    e.next = NEXT_DEF;
    return e;
  endfunction : tsi_default_entry

  // read one field of an entry
  function automatic logic [31:0] tsi_field_rd(tsi_entry_s e, logic [3:0] f);
    logic [31:0] v;
    v = 32'h00000000;
    unique case (f)
      4'(FLD_WIDTH): v = {19'h00000, e.width};
      4'(FLD_HEIGHT): v = {20'h00000, e.height};
      4'(FLD_OFFX): v = {19'h00000, e.offx};
      4'(FLD_OFFY): v = {20'h00000, e.offy};
      4'(FLD_GAIN): v = {16'h0000, e.gain};
      4'(FLD_GAINR): v = {16'h0000, e.gain_r};
      4'(FLD_GAINB): v = {16'h0000, e.gain_b};
      4'(FLD_EXPO): v = {8'h00, e.expo};
      4'(FLD_BLACK): v = {22'h000000, e.black};
      4'(FLD_BINH): v = {30'h00000000, e.binh};
      4'(FLD_BINV): v = {30'h00000000, e.binv};
      4'(FLD_LUT): v = {31'h00000000, e.lut};
      4'(FLD_COUNT): v = {16'h0000, e.count};
      4'(FLD_NEXT): v = {28'h0000000, e.next};
      default: v = 32'h00000000;
    endcase
    return v;
  endfunction : tsi_field_rd

  // entry selected for register access and the field an address names
  assign sel_e = s_r.tab[s_r.sel];
  wire [3:0] fidx = 4'(addr[7:2] - 6'(ADDR_FIELD >> 2)); // field of access
  wire is_field = addr >= ADDR_FIELD && addr[1:0] == 2'h0
    && (addr[7:2] - 6'(ADDR_FIELD >> 2)) < 6'(NUM_FIELDS); // field window

  // range check of a written value against the selected entry
  tsi_entry_check u_check (
    .field(fidx),
    .wdata(wdata[23:0]),
    .cur_width(sel_e.width),
    .cur_height(sel_e.height),
    .cur_binh(sel_e.binh),
    .cur_binv(sel_e.binv),
    .accept(accept)
  );

  //------------------------------------------------------------
  // next-state logic
  //------------------------------------------------------------
  // register port, table and sequencer
  always_comb begin
    tsi_entry_s e;
    logic wok;
    e = '0;
    wok = 1'b0;
    s_nxt = s_r;
    s_nxt.start = 1'b0;
    s_nxt.rdata = 32'h00000000;
    // register reads, answered in the next cycle only
    if (rd) begin
      if (addr == ADDR_MODE) begin
        // mode and overlap request as software wrote them
        s_nxt.rdata = {26'h0000000, s_r.ovl, 2'h0, s_r.mode};
      end else if (addr == ADDR_SEL) begin
        // entry open for field access
        s_nxt.rdata = {28'h0000000, s_r.sel};
      end else if (addr == ADDR_STAT) begin
        // status: repetitions, pointer, latest entry, busy
        s_nxt.rdata = {7'h00, s_r.rep, s_r.ptr, s_r.last, (s_r.st == ST_BUSY)};
      end else if (is_field) begin
        // one field of the selected entry
        s_nxt.rdata = tsi_field_rd(sel_e, fidx);
      end
      // anything else reads as zero
    end
    // register writes
    if (wr) begin
      if (addr == ADDR_MODE) begin
        // mode and overlap request are stored as written
        s_nxt.mode = wdata[1:0];
        s_nxt.ovl = wdata[MODE_OVL_POS+1:MODE_OVL_POS];
        // entering sequence mode starts over at entry zero
        if (wdata[1:0] == MODE_SEQ && s_r.mode != MODE_SEQ) begin
          s_nxt.ptr = 4'h0;
          s_nxt.rep = 16'h0000;
          s_nxt.last = 4'h0;
        end
      end else if (addr == ADDR_SEL) begin
        // a selection past the table is dropped
        if (wdata[31:0] < 32'(ENTRIES)) begin
          s_nxt.sel = wdata[3:0];
        end
      end else if (addr == ADDR_CMD) begin
        // reset command: pointer and repetitions back to the start
        if (wdata[CMD_RESET_BIT]) begin
          s_nxt.ptr = 4'h0;
          s_nxt.rep = 16'h0000;
        end
        // index read: report the latest entry once, then forget it
        if (wdata[CMD_READ_BIT]) begin
          s_nxt.rdata = {28'h0000000, s_r.last};
          s_nxt.last = 4'h0;
        end
      end else if (is_field) begin
        // merge the new field into a copy of the entry
        e = sel_e;
        // an illegal value leaves the entry untouched
        wok = accept && wdata[31:24] == 8'h00;
        unique case (fidx)
          4'(FLD_WIDTH): e.width = wdata[12:0];
          4'(FLD_HEIGHT): e.height = wdata[11:0];
          4'(FLD_OFFX): e.offx = wdata[12:0];
          4'(FLD_OFFY): e.offy = wdata[11:0];
          4'(FLD_GAIN): e.gain = wdata[15:0];
          4'(FLD_GAINR): e.gain_r = wdata[15:0];
          4'(FLD_GAINB): e.gain_b = wdata[15:0];
          4'(FLD_EXPO): e.expo = wdata[23:0];
          4'(FLD_BLACK): e.black = wdata[9:0];
          4'(FLD_BINH): e.binh = wdata[1:0];
          4'(FLD_BINV): e.binv = wdata[1:0];
          4'(FLD_LUT): e.lut = wdata[0];
          4'(FLD_COUNT): e.count = wdata[15:0];
          4'(FLD_NEXT): e.next = wdata[3:0];
          default: e = sel_e;
        endcase
        if (wok) begin
          s_nxt.tab[s_r.sel] = e;
        end
      end
    end
    // sequencer
    unique case (s_r.st)
      ST_IDLE: begin
        // a trigger in sequence mode latches the current entry
        if (trig && s_r.mode == MODE_SEQ) begin
          s_nxt.st = ST_BUSY;
          s_nxt.start = 1'b1;
          s_nxt.cidx = s_r.ptr;
          s_nxt.cap = s_r.tab[s_r.ptr];
          s_nxt.last = s_r.ptr;
          if (s_r.rep + 16'h0001 >= s_r.tab[s_r.ptr].count) begin
            // last repetition: follow the next-entry field
            s_nxt.ptr = s_r.tab[s_r.ptr].next;
            s_nxt.rep = 16'h0000;
          end else begin
            // more repetitions of this entry to come
            s_nxt.rep = s_r.rep + 16'h0001;
          end
        end
      end
      ST_BUSY: begin
        // triggers are dropped here, pointer untouched
        // leaving sequence mode also frees the sequencer
        if (capture_done || s_r.mode != MODE_SEQ) begin
          s_nxt.st = ST_IDLE;
        end
      end
    endcase
  end

  // state register
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      // every entry back to its defaults, sequencer idle
      s_r <= '0;
      s_r.st <= ST_IDLE;
      s_r.mode <= MODE_NORMAL;
      s_r.ovl <= OVL_OFF;
      for (int i = 0; i < ENTRIES; i++) begin
        s_r.tab[i] <= tsi_default_entry();
      end
      s_r.cap <= tsi_default_entry();
    end else begin
      // otherwise take the next state as a whole
      s_r <= s_nxt;
    end
  end

  //------------------------------------------------------------
  // outputs
  //------------------------------------------------------------
  // the command read value wins over a read strobe in the same cycle
  assign rdata = s_r.rdata;
  assign cap_start = s_r.start;
  assign busy = (s_r.st == ST_BUSY);
  logic ovl_r; // overlap output register
  // overlap grant, taken from the next state so it lines up with mode
  always_ff @(posedge clk_sys) begin
    if (srst) begin
      ovl_r <= 1'b0;
    end else begin
      ovl_r <= s_nxt.ovl == OVL_READOUT && s_nxt.mode != MODE_SEQ;
    end
  end
  assign overlap_readout = ovl_r;
  // capture parameters hold until the next start
  assign cap_index = s_r.cidx;
  assign cap_width = s_r.cap.width;
  assign cap_height = s_r.cap.height;
  assign cap_offx = s_r.cap.offx;
  assign cap_offy = s_r.cap.offy;
  assign cap_gain = s_r.cap.gain;
  assign cap_gain_r = s_r.cap.gain_r;
  assign cap_gain_b = s_r.cap.gain_b;
  assign cap_expo = s_r.cap.expo;
  assign cap_black = s_r.cap.black;
  assign cap_binh = s_r.cap.binh;
  assign cap_binv = s_r.cap.binv;
  assign cap_lut = s_r.cap.lut;

  //------------------------------------------------------------
  // checks
  //------------------------------------------------------------
  chk_idle_no_start: assert property (@(posedge clk_sys) disable iff (srst)
    s_r.mode != MODE_SEQ |=> !cap_start)
    else $error("capture started outside sequence mode");
  chk_busy_ignore: assert property (@(posedge clk_sys) disable iff (srst)
    (busy && trig && !capture_done && !wr) |=> ($stable(s_r.ptr) && !cap_start))
    else $error("trigger during capture changed state");
  chk_start_busy: assert property (@(posedge clk_sys) disable iff (srst)
    cap_start |-> busy && !$past(busy))
    else $error("capture start without entering busy");
  chk_no_overlap: assert property (@(posedge clk_sys) disable iff (srst)
    s_r.mode == MODE_SEQ |-> !overlap_readout)
    else $error("readout overlap active in sequence mode");
  chk_idx_legal: assert property (@(posedge clk_sys) disable iff (srst)
    s_r.sel < 4'(ENTRIES) && cap_index < 4'(ENTRIES))
    else $error("entry index out of range");
  chk_reset_cmd: assert property (@(posedge clk_sys) disable iff (srst)
    (wr && addr == ADDR_CMD && wdata[CMD_RESET_BIT] && !(busy == 1'b0 && trig
      && s_r.mode == MODE_SEQ)) |=> (s_r.ptr == 4'h0 && s_r.rep == 16'h0000))
    else $error("reset command did not clear pointer");
  chk_read_cmd: assert property (@(posedge clk_sys) disable iff (srst)
    (wr && addr == ADDR_CMD && wdata[CMD_READ_BIT] && !rd) |=>
      rdata == {28'h0000000, $past(s_r.last)})
    else $error("index read returned wrong entry");
  chk_width_range: assert property (@(posedge clk_sys) disable iff (srst)
    cap_start |-> cap_width >= WIDTH_MIN && cap_width <= WIDTH_MAX)
    else $error("capture width outside range");
  chk_cap_params: assert property (@(posedge clk_sys) disable iff (srst)
    cap_start |-> cap_expo == $past(s_r.tab[s_r.ptr].expo))
    else $error("capture exposure not taken from entry");
  // sequencer start and hold
  chk_seq_entry: assert property (@(posedge clk_sys) disable iff (srst)
    (wr && addr == ADDR_MODE && wdata[1:0] == MODE_SEQ && s_r.mode != MODE_SEQ)
      |=> (s_r.ptr == 4'h0 && s_r.rep == 16'h0000 && s_r.last == 4'h0))
    else $error("sequence mode did not restart at entry zero");
  chk_start_ptr: assert property (@(posedge clk_sys) disable iff (srst)
    cap_start |-> cap_index == $past(s_r.ptr))
    else $error("capture entry differs from pointer");
  chk_busy_hold: assert property (@(posedge clk_sys) disable iff (srst)
    (busy && !capture_done && s_r.mode == MODE_SEQ) |=> busy)
    else $error("busy dropped before capture end");
  // read data only in the cycle after a read
  chk_rdata_idle: assert property (@(posedge clk_sys) disable iff (srst)
    (!rd && !(wr && addr == ADDR_CMD && wdata[CMD_READ_BIT])) |=> rdata == 32'h00000000)
    else $error("read data not cleared between reads");
endmodule : tsi_seq_indexer
`default_nettype wire

/* File: verif/trigger_sequence_indexer_bench.sv */
// testbench: register port and trigger sequences of the sequence indexer
`timescale 1ns/1ps
`default_nettype none
module trigger_sequence_indexer_bench;
  import tsi_pkg::*;
  //------------------------------------------------------------
  // signals
  //------------------------------------------------------------
  logic clk_sys, srst, wr, rd, trig, capture_done, cap_start, busy, overlap_readout;
  logic cap_lut, slow; // lut flag, partner speed
  logic [7:0] addr; // register address
  logic [31:0] wdata, rdata, v; // bus data, read result
  logic [3:0] cap_index; // entry of capture
  logic [12:0] cap_width, cap_offx; // roi x
  logic [11:0] cap_height, cap_offy; // roi y
  logic [15:0] cap_gain, cap_gain_r, cap_gain_b; // gains
  logic [23:0] cap_expo; // exposure
  logic [9:0] cap_black; // black level
  logic [1:0] cap_binh, cap_binv; // binning
  int mismatches = 0; // failed comparisons
  int num_checks = 0; // all comparisons
  tsi_seq_indexer tsi_seq_indexer_i (.clk_sys(clk_sys), .srst(srst), .addr(addr),
    .wdata(wdata), .wr(wr), .rd(rd), .rdata(rdata), .trig(trig),
    .capture_done(capture_done), .cap_start(cap_start), .busy(busy),
    .overlap_readout(overlap_readout), .cap_index(cap_index), .cap_width(cap_width),
    .cap_height(cap_height), .cap_offx(cap_offx), .cap_offy(cap_offy),
    .cap_gain(cap_gain), .cap_gain_r(cap_gain_r), .cap_gain_b(cap_gain_b),
    .cap_expo(cap_expo), .cap_black(cap_black), .cap_binh(cap_binh),
    .cap_binv(cap_binv), .cap_lut(cap_lut));
  tsi_sensor_model tsi_sensor_model_i (.clk_sys(clk_sys), .srst(srst),
    .cap_start(cap_start), .slow(slow), .capture_done(capture_done));
  //------------------------------------------------------------
  // tasks
  //------------------------------------------------------------
  // compare one value and report a mismatch at once
  task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string nm);
    num_checks++;
    if (seen !== exp) begin
      mismatches++;
      $display("CHECK FAILED %s expected %h seen %h", nm, exp, seen);
    end
  endtask : check
  // print counts and verdict, then stop
  task automatic final_report();
    $display("checks %0d mismatches %0d", num_checks, mismatches);
    if (mismatches == 0 && num_checks > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : final_report
  // one-cycle register write
  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    wdata <= d;
    wr <= 1'b1;
    @(posedge clk_sys);
    wr <= 1'b0;
  endtask : wr_reg
  // one-cycle register read, data taken in the following cycle
  task automatic rd_reg(input logic [7:0] a, output logic [31:0] d);
    @(posedge clk_sys);
    addr <= a;
    rd <= 1'b1;
    @(posedge clk_sys);
    rd <= 1'b0;
    #1;
    d = rdata;
  endtask : rd_reg
  // write one field of one table entry
  task automatic wf(input int sel, input int f, input logic [31:0] d);
    wr_reg(ADDR_SEL, 32'(sel));
    wr_reg(ADDR_FIELD + 8'(4 * f), d);
  endtask : wf
  // one trigger pulse, then look for the start pulse and entry
  task automatic fire(input logic go, input logic [3:0] idx, input string nm);
    @(posedge clk_sys);
    trig <= 1'b1;
    @(posedge clk_sys);
    trig <= 1'b0;
    #1;
    check(cap_start, go, nm);
    check(cap_index, idx, nm);
  endtask : fire
  // bounded wait for the capture to end, plus a short trigger gap
  task automatic wait_idle();
    int n;
    n = 0;
    while (busy !== 1'b0 && n < 200) begin
      @(posedge clk_sys);
      #1;
      n++;
    end
    check(busy, 1'b0, "busy end");
    repeat (2) @(posedge clk_sys);
  endtask : wait_idle
  //------------------------------------------------------------
  // clock and watchdog
  //------------------------------------------------------------
  initial begin
    clk_sys = 1'b0;
    forever #5 clk_sys = ~clk_sys;
  end
  initial begin
    repeat (20000) @(posedge clk_sys);
    mismatches++;
    final_report();
  end
  //------------------------------------------------------------
  // main sequence
  //------------------------------------------------------------
  initial begin
    srst = 1'b1;
    trig = 1'b0;
    wr = 1'b0;
    rd = 1'b0;
    addr = 8'h00;
    wdata = 32'h00000000;
    slow = 1'b1;
    repeat (16) @(posedge clk_sys);
    srst <= 1'b0;
    #1;
    check(cap_width, WIDTH_MAX, "default width");
    check(cap_height, HEIGHT_MAX, "default height");
    check(cap_expo, EXPO_DEF, "default expo");
    check(cap_black, 10'h000, "default black");
    check(cap_lut, 1'b0, "default lut");
    check({cap_binh, cap_binv}, {BIN_OFF, BIN_OFF}, "default binning");
    wr_reg(ADDR_MODE, 32'h00000010);
    #1;
    check(overlap_readout, 1'b1, "overlap normal");
    fire(1'b0, 4'h0, "normal mode trigger");
    // entry 0: own gains, exposure, black, lut, two frames, then entry 3
    wf(0, FLD_GAIN, 32'h00000123);
    wf(0, FLD_GAINR, 32'h00000456);
    wf(0, FLD_GAINB, 32'h00000789);
    wf(0, FLD_EXPO, 32'h00000100);
    wf(0, FLD_BLACK, 32'h00000005);
    wf(0, FLD_LUT, 32'h00000001);
    wf(0, FLD_COUNT, 32'h00000002);
    wf(0, FLD_NEXT, 32'h00000003);
    // entry 3: h binning on, illegal width and x offset refused
    wf(3, FLD_WIDTH, 32'h000007D0);
    wf(3, FLD_WIDTH, 32'h00000007);
    wf(3, FLD_BINH, 32'h00000002);
    wf(3, FLD_OFFX, 32'h00000230);
    wf(3, FLD_OFFX, 32'h00000231);
    wf(3, FLD_NEXT, 32'h00000009);
    // entry 9: v binning on, illegal height and y offset refused
    wf(9, FLD_HEIGHT, 32'h000003E8);
    wf(9, FLD_HEIGHT, 32'h00000001);
    wf(9, FLD_BINV, 32'h00000002);
    wf(9, FLD_OFFY, 32'h00000398);
    wf(9, FLD_OFFY, 32'h00000399);
    wf(10, FLD_WIDTH, 32'h00000068);
    wr_reg(ADDR_MODE, 32'h00000011);
    #1;
    check(overlap_readout, 1'b0, "overlap in sequence");
    fire(1'b1, 4'h0, "first trigger");
    check({cap_gain, cap_gain_r}, 32'h01230456, "gains");
    check(cap_gain_b, 16'h0789, "blue gain");
    check(cap_expo, 24'h000100, "entry expo");
    check(cap_black, 10'h005, "entry black");
    check(cap_lut, 1'b1, "entry lut");
    fire(1'b0, 4'h0, "trigger while busy");
    slow = 1'b0;
    wait_idle();
    fire(1'b1, 4'h0, "entry repeat");
    wait_idle();
    fire(1'b1, 4'h3, "next entry");
    check(cap_width, 13'h07D0, "width kept");
    check(cap_offx, 13'h0230, "x offset limit");
    check({cap_binh, cap_binv}, {BIN_ON, BIN_OFF}, "h binning");
    check(cap_expo, EXPO_DEF, "expo default entry");
    check({cap_black, cap_lut}, 11'h000, "black lut default");
    wait_idle();
    wr_reg(ADDR_CMD, 32'h00000002);
    #1;
    check(rdata, 32'h00000003, "index read");
    wr_reg(ADDR_CMD, 32'h00000002);
    #1;
    check(rdata, 32'h00000000, "index read again");
    fire(1'b1, 4'h9, "last position");
    check(cap_height, 12'h3E8, "height kept");
    check(cap_offy, 12'h398, "y offset limit");
    check(cap_binv, BIN_ON, "v binning");
    check(cap_width, 13'h0068, "select ten ignored");
    wait_idle();
    fire(1'b1, 4'h0, "default next");
    wait_idle();
    wr_reg(ADDR_CMD, 32'h00000001);
    fire(1'b1, 4'h0, "after reset cmd");
    wait_idle();
    fire(1'b1, 4'h0, "count restarted");
    wait_idle();
    fire(1'b1, 4'h3, "advance after reset");
    wait_idle();
    rd_reg(ADDR_STAT, v);
    check(32'(v[8:0]), 32'h00000126, "status ptr last busy");
    rd_reg(8'h80, v);
    check(v, 32'h00000000, "unmapped read");
    wf(0, FLD_BINH, 32'h00000002);
    wf(0, FLD_OFFX, 32'h00000001);
    rd_reg(ADDR_FIELD + 8'(4 * FLD_OFFX), v);
    check(v, 32'h00000000, "x offset past binned width");
    wr_reg(ADDR_MODE, 32'h00000000);
    fire(1'b0, 4'h3, "mode left");
    final_report();
  end
endmodule : trigger_sequence_indexer_bench
`default_nettype wire

/* File: verif/tsi_sensor_model.sv */
// sensor path model: answers each capture start with a one-cycle done pulse
`timescale 1ns/1ps
`default_nettype none
module tsi_sensor_model #(
  parameter int FAST = 3, // cycles from start to done, prompt answer
  parameter int SLOW = 40 // cycles from start to done, slow answer
)(
  input wire logic clk_sys, // system clock
  input wire logic srst, // synchronous reset, high
  input wire logic cap_start, // capture start pulse from the block
  input wire logic slow, // choose the slow answer
  output logic capture_done // end of exposure and readout
);
  //------------------------------------------------------------
  // capture timing
  //------------------------------------------------------------
  int cnt; // cycles left of the running capture
  // count down from each start and pulse done when it runs out
  always_ff @(posedge clk_sys) begin
    capture_done <= 1'b0;
    if (srst) begin
      cnt <= 0;
    end else if (cap_start) begin
      cnt <= slow ? SLOW : FAST; // capture length picked per start
    end else if (cnt == 1) begin
      cnt <= 0;
      capture_done <= 1'b1;
    end else if (cnt > 1) begin
      cnt <= cnt - 1;
    end
  end
endmodule : tsi_sensor_model
`default_nettype wire
